// ---- pkg/rwf_pkg.sv ----
// package: register map, fields and constants of the receive watermark flow-control engine
package rwf_pkg;
  localparam int unsigned APB_AW = 8;
  localparam logic [7:0] OFF_WATERMARK = 8'h00;
  localparam logic [7:0] OFF_CONTROL_TWO = 8'h04;
  localparam logic [7:0] OFF_PAUSE_OP = 8'h08;
  localparam logic [7:0] OFF_PAUSE_TIME = 8'h0C;
  localparam logic [7:0] OFF_MAC_CTRL_ONE = 8'h10;
  localparam logic [7:0] OFF_RX_STATUS = 8'h14;
  localparam logic [7:0] OFF_RX_RELEASE = 8'h18;
  localparam logic [7:0] OFF_RX_WRITE = 8'h1C;
  localparam int unsigned FULL_WM_HI = 15;
  localparam int unsigned FULL_WM_LO = 8;
  localparam int unsigned EMPTY_WM_HI = 7;
  localparam int unsigned EMPTY_WM_LO = 0;
  localparam logic [7:0] FULL_WM_RESET = 8'h10;
  localparam logic [7:0] EMPTY_WM_RESET = 8'h0F;
  localparam int unsigned AUTO_EN_BIT = 7;
  localparam logic [15:0] PAUSE_TIME_RESET = 16'h1000;
  localparam logic [15:0] MAC_CTRL_ONE_RESET = 16'h000D;
  localparam logic [15:0] MAC_CTRL_ONE_WMASK = 16'hCF1F;
  localparam logic [15:0] MAC_CTRL_ONE_ZMASK = 16'h3000;
  localparam int unsigned BLOCK_BYTES = 96;
  localparam int unsigned QUANTUM_BITS = 512;
  localparam int unsigned PAUSE_GAP_CYCLES = 64;
  typedef enum logic [1:0] {
    RWF_OP_IDLE = 2'b00,
    RWF_OP_SINGLE = 2'b01,
    RWF_OP_CONT = 2'b10,
    RWF_OP_END = 2'b11
  } rwf_op_t;
  typedef enum logic [1:0] {
    RWF_AUTO_IDLE = 2'b00,
    RWF_AUTO_ACTIVE = 2'b01
  } rwf_auto_t;
endpackage

// ---- src/rwf_occupancy.sv ----
// receive buffer occupancy counter in bytes and whole 96-byte blocks
`timescale 1ns/100ps
`default_nettype none
module rwf_occupancy #(
  parameter int unsigned CNT_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_valid,
  input wire logic [CNT_W-1:0] wr_bytes,
  input wire logic rel_valid,
  input wire logic [CNT_W-1:0] rel_bytes,
  output logic [CNT_W-1:0] bytes_reg,
  output logic [CNT_W-1:0] blocks
);
  import rwf_pkg::*;
  logic [CNT_W-1:0] add_v;
  logic [CNT_W-1:0] sub_v;
  logic [CNT_W:0] sum_v;
  initial begin
    if (CNT_W < 8 || CNT_W > 24) $error("rwf_occupancy: CNT_W out of range");
  end
  // written minus released, saturating at both ends
  always_comb begin
    add_v = wr_valid ? wr_bytes : '0;
    sub_v = rel_valid ? rel_bytes : '0;
    sum_v = {1'b0, bytes_reg} + {1'b0, add_v};
    if (sum_v[CNT_W]) begin
      sum_v = {1'b0, {CNT_W{1'b1}}};
    end
    if (sum_v < {1'b0, sub_v}) begin
      sum_v = '0;
    end else begin
      sum_v = sum_v - {1'b0, sub_v};
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bytes_reg <= '0;
    end else begin
      bytes_reg <= sum_v[CNT_W-1:0];
    end
  end
  assign blocks = CNT_W'(bytes_reg / CNT_W'(BLOCK_BYTES));
endmodule
`default_nettype wire

// ---- src/rwf_pause_tx.sv ----
// pause frame and jam request sequencer driven by the operation field
`timescale 1ns/100ps
`default_nettype none
module rwf_pause_tx #(
  parameter int unsigned GAP = 64
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic full_duplex,
  input wire logic [1:0] op,
  input wire logic [15:0] pause_time,
  input wire logic frame_done,
  output logic frame_req_reg,
  output logic [15:0] frame_quanta_reg,
  output logic jam_reg,
  output logic op_clear
);
  import rwf_pkg::*;
  logic [15:0] gap_cnt_reg;
  logic busy_reg;
  logic [1:0] frame_op_reg;
  initial begin
    if (GAP < 1 || GAP > 65535) $error("rwf_pause_tx: GAP out of range");
  end
  // one-shot codes return to idle once their frame is sent
  assign op_clear = full_duplex && busy_reg && frame_done && (op == frame_op_reg) &&
    (op == RWF_OP_SINGLE || op == RWF_OP_END);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_req_reg <= 1'b0;
      frame_quanta_reg <= 16'h0000;
      frame_op_reg <= RWF_OP_IDLE;
      busy_reg <= 1'b0;
      gap_cnt_reg <= 16'h0000;
    end else if (busy_reg) begin
      // a started frame is always finished
      if (frame_done) begin
        frame_req_reg <= 1'b0;
        busy_reg <= 1'b0;
        gap_cnt_reg <= 16'(GAP);
      end
    end else if (!full_duplex || op == RWF_OP_IDLE) begin
      frame_req_reg <= 1'b0;
      gap_cnt_reg <= 16'h0000;
    end else if (gap_cnt_reg != 16'h0000) begin
      gap_cnt_reg <= gap_cnt_reg - 16'h0001;
    end else begin
      frame_req_reg <= 1'b1;
      busy_reg <= 1'b1;
      frame_op_reg <= op;
      frame_quanta_reg <= (op == RWF_OP_END) ? 16'h0000 : pause_time;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      jam_reg <= 1'b0;
    end else begin
      jam_reg <= !full_duplex && (op != RWF_OP_IDLE);
    end
  end
endmodule
`default_nettype wire

// ---- src/rwf_top.sv ----
// receive watermark flow-control engine with APB register slave
// Overview of operation
// - auto mode starts flow control at upper watermark
// - auto mode stops below lower watermark
// - watermarks: high byte full, low byte empty
// - full field bits 15:8, default 16
// - empty field bits 7:0, default 15
// - hardware owns operation field in auto mode
// - auto status reads 10 active, 00 idle
// - enable clear at reset: manual flow control
// - full duplex 10 repeats pause frames
// - half duplex nonzero jams, 00 disables
// - pause time unit is 512 bit times
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module rwf_top #(
  parameter int unsigned CNT_W = 16,
  parameter int unsigned GAP = rwf_pkg::PAUSE_GAP_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rwf_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic full_duplex,
  input wire logic rx_wr_valid,
  input wire logic [CNT_W-1:0] rx_wr_bytes,
  input wire logic pause_frame_done,
  output logic pause_frame_req,
  output logic [15:0] pause_frame_quanta,
  output logic jam_req,
  output logic mac_loopback_enable,
  output logic pause_frame_receive_enable,
  output logic accept_every_frame
);
  import rwf_pkg::*;
  logic [15:0] watermark_register_reg;
  logic [15:0] pause_time_register_reg;
  logic [15:0] mac_control_one_reg;
  logic auto_pause_enable_reg;
  logic [1:0] pause_operation_field_reg;
  logic [1:0] pause_operation_field_next;
  rwf_auto_t auto_state_reg;
  rwf_auto_t auto_state_next;
  logic fd_meta_reg;
  logic fd_sync_reg;
  logic done_meta_reg;
  logic done_sync_reg;
  logic done_prev_reg;
  logic done_pulse;
  logic [CNT_W-1:0] occ_bytes;
  logic [CNT_W-1:0] occ_blocks;
  logic [7:0] full_watermark;
  logic [7:0] empty_watermark;
  logic wr_en;
  logic addr_ok;
  logic rel_valid;
  logic [CNT_W-1:0] rel_bytes;
  logic op_clear;
  logic frame_req_w;
  logic [15:0] frame_quanta_w;
  logic jam_w;
  logic [31:0] rdata_next;
  initial begin
    if (CNT_W < 16 || CNT_W > 24) $error("rwf_top: CNT_W out of range");
  end

  // full_duplex and pause_frame_done pins through two flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fd_meta_reg <= 1'b0;
      fd_sync_reg <= 1'b0;
      done_meta_reg <= 1'b0;
      done_sync_reg <= 1'b0;
      done_prev_reg <= 1'b0;
    end else begin
      fd_meta_reg <= full_duplex;
      fd_sync_reg <= fd_meta_reg;
      done_meta_reg <= pause_frame_done;
      done_sync_reg <= done_meta_reg;
      done_prev_reg <= done_sync_reg;
    end
  end
  assign done_pulse = done_sync_reg && !done_prev_reg;

  // apb decode, zero wait states
  assign wr_en = psel && penable && pwrite;
  always_comb begin
    case (paddr)
      OFF_WATERMARK, OFF_CONTROL_TWO, OFF_PAUSE_OP, OFF_PAUSE_TIME,
      OFF_MAC_CTRL_ONE, OFF_RX_STATUS, OFF_RX_RELEASE: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign rel_valid = wr_en && (paddr == OFF_RX_RELEASE) && pstrb[0];
  assign rel_bytes = pwdata[CNT_W-1:0];
  assign full_watermark = watermark_register_reg[FULL_WM_HI:FULL_WM_LO];
  assign empty_watermark = watermark_register_reg[EMPTY_WM_HI:EMPTY_WM_LO];

  // watermark register, byte-wise writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watermark_register_reg <= {FULL_WM_RESET, EMPTY_WM_RESET};
    end else if (wr_en && paddr == OFF_WATERMARK) begin
      if (pstrb[0]) begin
        watermark_register_reg[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        watermark_register_reg[15:8] <= pwdata[15:8];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_time_register_reg <= PAUSE_TIME_RESET;
    end else if (wr_en && paddr == OFF_PAUSE_TIME) begin
      if (pstrb[0]) begin
        pause_time_register_reg[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        pause_time_register_reg[15:8] <= pwdata[15:8];
      end
    end
  end

  // mac control one: writable bits only, unimplemented read zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mac_control_one_reg <= MAC_CTRL_ONE_RESET;
    end else if (wr_en && paddr == OFF_MAC_CTRL_ONE) begin
      if (pstrb[0]) begin
        mac_control_one_reg[7:0] <= pwdata[7:0] & MAC_CTRL_ONE_WMASK[7:0];
      end
      if (pstrb[1]) begin
        mac_control_one_reg[15:8] <= pwdata[15:8] & MAC_CTRL_ONE_WMASK[15:8];
      end
    end
  end

  // second control register, enable bit clear after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_pause_enable_reg <= 1'b0;
    end else if (wr_en && paddr == OFF_CONTROL_TWO && pstrb[0]) begin
      auto_pause_enable_reg <= pwdata[AUTO_EN_BIT];
    end
  end

  // automatic engine with hysteresis
  always_comb begin
    auto_state_next = auto_state_reg;
    case (auto_state_reg)
      RWF_AUTO_IDLE: begin
        if (auto_pause_enable_reg && occ_blocks >= CNT_W'(full_watermark)) begin
          auto_state_next = RWF_AUTO_ACTIVE;
        end
      end
      RWF_AUTO_ACTIVE: begin
        if (!auto_pause_enable_reg) begin
          auto_state_next = RWF_AUTO_IDLE;
        end else if (occ_blocks < CNT_W'(empty_watermark)) begin
          auto_state_next = RWF_AUTO_IDLE;
        end
      end
      default: auto_state_next = RWF_AUTO_IDLE;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_state_reg <= RWF_AUTO_IDLE;
    end else begin
      auto_state_reg <= auto_state_next;
    end
  end

  // operation field: hardware-owned in auto, software-written in manual
  always_comb begin
    pause_operation_field_next = pause_operation_field_reg;
    if (auto_pause_enable_reg) begin
      pause_operation_field_next = (auto_state_next == RWF_AUTO_ACTIVE) ? RWF_OP_CONT : RWF_OP_IDLE;
    end else if (wr_en && paddr == OFF_PAUSE_OP && pstrb[0]) begin
      pause_operation_field_next = pwdata[1:0];
    end else if (op_clear) begin
      pause_operation_field_next = RWF_OP_IDLE;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_operation_field_reg <= RWF_OP_IDLE;
    end else begin
      pause_operation_field_reg <= pause_operation_field_next;
    end
  end

  rwf_occupancy #(
    .CNT_W(CNT_W)
  ) u_occ (
    .pclk(pclk),
    .presetn(presetn),
    .wr_valid(rx_wr_valid),
    .wr_bytes(rx_wr_bytes),
    .rel_valid(rel_valid),
    .rel_bytes(rel_bytes),
    .bytes_reg(occ_bytes),
    .blocks(occ_blocks)
  );

  rwf_pause_tx #(
    .GAP(GAP)
  ) u_ptx (
    .pclk(pclk),
    .presetn(presetn),
    .full_duplex(fd_sync_reg),
    .op(pause_operation_field_reg),
    .pause_time(pause_time_register_reg),
    .frame_done(done_pulse),
    .frame_req_reg(frame_req_w),
    .frame_quanta_reg(frame_quanta_w),
    .jam_reg(jam_w),
    .op_clear(op_clear)
  );

  // output flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_frame_req <= 1'b0;
      pause_frame_quanta <= 16'h0000;
      jam_req <= 1'b0;
      mac_loopback_enable <= 1'b0;
      pause_frame_receive_enable <= 1'b1;
      accept_every_frame <= 1'b0;
    end else begin
      pause_frame_req <= frame_req_w;
      pause_frame_quanta <= frame_quanta_w;
      jam_req <= jam_w;
      mac_loopback_enable <= mac_control_one_reg[4];
      pause_frame_receive_enable <= mac_control_one_reg[2];
      accept_every_frame <= mac_control_one_reg[1];
    end
  end

  // read mux
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (paddr)
      OFF_WATERMARK: rdata_next[15:0] = watermark_register_reg;
      OFF_CONTROL_TWO: rdata_next[AUTO_EN_BIT] = auto_pause_enable_reg;
      OFF_PAUSE_OP: rdata_next[1:0] = pause_operation_field_reg;
      OFF_PAUSE_TIME: rdata_next[15:0] = pause_time_register_reg;
      OFF_MAC_CTRL_ONE: rdata_next[15:0] = mac_control_one_reg & ~MAC_CTRL_ONE_ZMASK;
      OFF_RX_STATUS: rdata_next[CNT_W-1:0] = occ_bytes;
      default: rdata_next = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      prdata <= (psel && !penable && !pwrite) ? rdata_next : 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// ---- verif/rwf_top_asserts.sv ----
// checker: bus and output relations of the flow-control engine
`timescale 1ns/100ps
`default_nettype none
module rwf_top_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic full_duplex,
  input wire logic pause_frame_done,
  input wire logic pause_frame_req,
  input wire logic [15:0] pause_frame_quanta,
  input wire logic jam_req
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  a_ready_single: assert property (pready |=> !pready) else $error("ready longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable) else $error("ready outside access");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("read data outside access");
  a_req_ends_done: assert property ($fell(pause_frame_req) |->
    $past(pause_frame_done, 2) || $past(pause_frame_done, 3) || $past(pause_frame_done, 4))
    else $error("pause request dropped early");
  a_quanta_steady: assert property (pause_frame_req && $past(pause_frame_req) |-> $stable(pause_frame_quanta))
    else $error("quanta changed in frame");
  a_no_jam_full: assert property (full_duplex [*5] |-> !jam_req) else $error("jam on full duplex");
  c_frame: cover property (pause_frame_req && pause_frame_done);
  c_jam: cover property (jam_req);
  c_err: cover property (pslverr);
endmodule
bind rwf_top rwf_top_asserts chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .full_duplex(full_duplex),
  .pause_frame_done(pause_frame_done), .pause_frame_req(pause_frame_req),
  .pause_frame_quanta(pause_frame_quanta), .jam_req(jam_req));
`default_nettype wire

// ---- verif/rwf_link_partner.sv ----
// transmit side model: completes each requested pause frame, alternately fast and slow
`timescale 1ns/100ps
`default_nettype none
module rwf_link_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pause_frame_req,
  output logic pause_frame_done
);
  logic [3:0] wait_reg;
  logic slow_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_frame_done <= 1'b0;
      wait_reg <= 4'h0;
      slow_reg <= 1'b0;
    end else if (!pause_frame_req) begin
      pause_frame_done <= 1'b0;
      wait_reg <= 4'h0;
    end else if (wait_reg == (slow_reg ? 4'hB : 4'h1)) begin
      pause_frame_done <= 1'b1;
      if (!pause_frame_done) slow_reg <= !slow_reg;
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
// testbench: register and flow-control sequences over the bus
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) check_val(32'(g), 32'(e))
module tb;
  import rwf_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, full_duplex, rx_wr_valid;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] rx_wr_bytes, pause_frame_quanta;
  logic pready, pslverr, pause_frame_done, pause_frame_req, jam_req, rerr;
  logic mac_loopback_enable, pause_frame_receive_enable, accept_every_frame;
  logic [1:0] ops [3] = '{2'b01, 2'b11, 2'b10};
  logic [15:0] quanta [3] = '{PAUSE_TIME_RESET, 16'h0000, PAUSE_TIME_RESET};
  int mismatches = 0, samples_checked = 0, cyc = 0;
  rwf_top #(.CNT_W(16), .GAP(4)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .full_duplex(full_duplex), .rx_wr_valid(rx_wr_valid), .rx_wr_bytes(rx_wr_bytes),
    .pause_frame_done(pause_frame_done), .pause_frame_req(pause_frame_req),
    .pause_frame_quanta(pause_frame_quanta), .jam_req(jam_req), .mac_loopback_enable(mac_loopback_enable),
    .pause_frame_receive_enable(pause_frame_receive_enable), .accept_every_frame(accept_every_frame));
  rwf_link_partner lp (.pclk(pclk), .presetn(presetn), .pause_frame_req(pause_frame_req),
    .pause_frame_done(pause_frame_done));
  always #2 pclk = ~pclk;
  task check_val(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task poll_op(input logic [1:0] e);
    int n;
    n = 0;
    do begin apb(1'b0, OFF_PAUSE_OP, 32'h0); n++; end while (rdat[1:0] !== e && n < 40);
    `CHK(rdat[1:0], e);
  endtask
  task wait_req(input logic v);
    int n;
    n = 0;
    while (pause_frame_req !== v && n < 200) begin @(posedge pclk); n++; end
    `CHK(pause_frame_req, v);
  endtask
  task rx_add(input logic [15:0] b);
    @(posedge pclk);
    rx_wr_valid <= 1'b1; rx_wr_bytes <= b;
    @(posedge pclk);
    rx_wr_valid <= 1'b0;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin mismatches++; conclude(); end
  end
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    full_duplex = 0; rx_wr_valid = 0; rx_wr_bytes = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFF_WATERMARK, 0); `CHK(rdat, {16'h0, FULL_WM_RESET, EMPTY_WM_RESET});
    apb(0, OFF_PAUSE_TIME, 0); `CHK(rdat, PAUSE_TIME_RESET);
    apb(0, OFF_CONTROL_TWO, 0); `CHK(rdat, 0);
    apb(0, OFF_MAC_CTRL_ONE, 0); `CHK(rdat, MAC_CTRL_ONE_RESET);
    `CHK(pause_frame_receive_enable, 1);
    apb(0, 8'h40, 0); `CHK(rerr, 1);
    `CHK(rdat, 0);
    $display("test reset_values done");
    full_duplex <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      apb(1, OFF_PAUSE_OP, 32'(ops[i]));
      wait_req(1); `CHK(pause_frame_quanta, quanta[i]);
      wait_req(0);
      if (ops[i] == 2'b10) begin
        wait_req(1); apb(1, OFF_PAUSE_OP, 32'h3);
        wait_req(0); wait_req(1); `CHK(pause_frame_quanta, 16'h0000);
      end
      poll_op(2'b00);
    end
    $display("test manual_pause done");
    apb(1, OFF_PAUSE_TIME, 32'h0042);
    apb(1, OFF_WATERMARK, 32'h0301);
    apb(1, OFF_CONTROL_TWO, 32'h80);
    rx_add(16'(3 * BLOCK_BYTES - 1));
    apb(0, OFF_PAUSE_OP, 0); `CHK(rdat, 0);
    rx_add(16'h1);
    apb(0, OFF_PAUSE_OP, 0); `CHK(rdat, 2);
    apb(0, OFF_RX_STATUS, 0); `CHK(rdat, 3 * BLOCK_BYTES);
    wait_req(1); `CHK(pause_frame_quanta, 16'h0042);
    apb(1, OFF_PAUSE_OP, 0); apb(0, OFF_PAUSE_OP, 0); `CHK(rdat, 2);
    for (int i = 0; i < 3; i++) begin
      apb(1, OFF_RX_RELEASE, (i == 2) ? 32'h1 : BLOCK_BYTES);
      apb(0, OFF_PAUSE_OP, 0); `CHK(rdat, (i == 2) ? 0 : 2);
    end
    apb(1, OFF_CONTROL_TWO, 0);
    $display("test auto_watermark done");
    wait_req(0);
    full_duplex <= 1'b0;
    apb(1, OFF_PAUSE_OP, 32'h2); apb(0, OFF_PAUSE_OP, 0); `CHK(jam_req, 1);
    apb(1, OFF_PAUSE_OP, 32'h0); apb(0, OFF_PAUSE_OP, 0); `CHK(jam_req, 0);
    $display("test half_duplex done");
    apb(1, OFF_MAC_CTRL_ONE, 32'h0016);
    repeat (2) @(posedge pclk);
    `CHK({mac_loopback_enable, accept_every_frame}, 2'b11);
    apb(0, OFF_MAC_CTRL_ONE, 0); `CHK(rdat, 32'h0016 & {16'h0, MAC_CTRL_ONE_WMASK});
    $display("test mac_control done");
    conclude();
  end
endmodule
`default_nettype wire
